/* File: rtl/nla_consts.svh */
// Constants for the nibble logic and immediate datapath
// Notes on behaviour
// - Direct xor combines addressed memory nibble with result_holder into result_holder.
// - Starred direct logic ops write result to result_holder and the same memory location.
// - Indexed logic ops fetch the memory operand at indexed_pointer address.
// - Direct or combines addressed memory nibble with result_holder into result_holder.
// - Indexed or uses indexed nibble; starred form stores result at that address.
// - Indexed starred and writes result to result_holder and the indexed location.
// - Indexed xor uses indexed nibble; starred form writes result back there.
// - add_imm_with_carry sums working_operand, immediate and carry_bit into result_holder.
// - sub_imm_with_borrow sums working_operand, inverted immediate and carry_bit.
// - Starred immediate ops also write result into the selected working_operand.
// - add_imm_set_carry adds working_operand and immediate without incoming carry.
// - sub_imm_plain adds working_operand, inverted immediate and one.
// - Add and subtract immediate ops other than add_imm_keep_carry update carry_bit with the 4-bit carry out.
// - add_imm_keep_carry adds but leaves carry_bit unchanged.
// - and_imm ands working_operand with immediate; starred form writes working_operand.
// - xor_imm xors working_operand with immediate; starred form writes working_operand.
// - The immediate is a full 4-bit field, any code 0 to 15.
`ifndef NLA_CONSTS_SVH
`define NLA_CONSTS_SVH
`define NLA_NIB_W         4
`define NLA_ADDR_W        7
`define NLA_WREG_SEL_W    4
`define NLA_RESULT_RST    4'h0
`define NLA_CARRY_RST     1'h0
`endif

/* File: rtl/nla_pkg.sv */
// Types shared by the nibble logic and immediate datapath
package nla_pkg;
    typedef enum logic [3:0] {
        NLA_OP_NONE,
        NLA_OP_XOR_MEM,
        NLA_OP_OR_MEM,
        NLA_OP_AND_MEM,
        NLA_OP_ADC_IMM,
        NLA_OP_SBC_IMM,
        NLA_OP_ADD_IMM,
        NLA_OP_SUB_IMM,
        NLA_OP_ADN_IMM,
        NLA_OP_AND_IMM,
        NLA_OP_XOR_IMM
    } nla_op_e;

    typedef struct packed {
        nla_op_e    op;
        logic       star;
        logic       indexed;
        logic [6:0] addr;
        logic [3:0] wsel;
        logic [3:0] imm;
    } nla_cmd_s;

    typedef struct packed {
        logic       we;
        logic [6:0] addr;
        logic [3:0] data;
    } nla_wr_s;
endpackage : nla_pkg

/* File: rtl/nla_logic_unit.sv */
// Bitwise logic unit shared by memory and immediate forms
`timescale 1ns/1ns
module nla_logic_unit (
    input  wire nla_pkg::nla_op_e i_op,
    input  wire logic [3:0]       i_a,
    input  wire logic [3:0]       i_b,
    output logic      [3:0]       o_y,
    output logic                  o_is_logic
);
    always_comb begin
        o_y        = 4'h0;
        o_is_logic = 1'b1;
        unique case (i_op)
            nla_pkg::NLA_OP_XOR_MEM, nla_pkg::NLA_OP_XOR_IMM: o_y = i_a ^ i_b;
            nla_pkg::NLA_OP_OR_MEM:                          o_y = i_a | i_b;
            nla_pkg::NLA_OP_AND_MEM, nla_pkg::NLA_OP_AND_IMM: o_y = i_a & i_b;
            default: o_is_logic = 1'b0;
        endcase
    end
endmodule : nla_logic_unit

/* File: rtl/nla_adder.sv */
// Four-bit adder with operand inversion and carry input
`timescale 1ns/1ns
module nla_adder (
    input  wire logic [3:0] i_a,
    input  wire logic [3:0] i_b,
    input  wire logic       i_invert,
    input  wire logic       i_cin,
    output logic      [3:0] o_sum,
    output logic            o_cout
);
    logic [4:0] sum5;
    always_comb begin
        sum5   = {1'b0, i_a} + {1'b0, (i_invert ? ~i_b : i_b)} + {4'h0, i_cin};
        o_sum  = sum5[3:0];
        o_cout = sum5[4];
    end
endmodule : nla_adder

/* File: rtl/nla_alu.sv */
// Nibble logic and immediate arithmetic datapath top level
`timescale 1ns/1ns
`include "nla_consts.svh"
module nla_alu (
    input  wire logic             I_CLK,
    input  wire logic             I_RESET,
    input  wire nla_pkg::nla_cmd_s i_CMD,
    input  wire logic       [6:0] i_INDEX_PTR,
    input  wire logic       [3:0] i_MEM_RDATA,
    input  wire logic       [3:0] i_WREG_RDATA,
    output logic            [6:0] o_MEM_RADDR,
    output logic            [3:0] o_WREG_RSEL,
    output nla_pkg::nla_wr_s      o_MEM_WR,
    output logic                  o_WREG_WE,
    output logic            [3:0] o_WREG_WSEL,
    output logic            [3:0] o_WREG_WDATA,
    output logic            [3:0] o_RESULT,
    output logic                  o_CARRY
);
    // ************************************************************
    // Operand selection
    // ************************************************************
    logic [3:0] result_holder_q;
    logic       carry_bit_q;
    logic       is_mem_op;
    logic       is_imm_op;
    logic [3:0] logic_a;
    logic [3:0] logic_y;
    logic       logic_hit;
    logic [3:0] sum;
    logic       cout;
    logic       sub_sel;
    logic       cin;
    logic [3:0] result_d;
    logic       carry_d;

    function automatic logic op_is_mem(input nla_pkg::nla_op_e op);
        return (op == nla_pkg::NLA_OP_XOR_MEM) || (op == nla_pkg::NLA_OP_OR_MEM) ||
               (op == nla_pkg::NLA_OP_AND_MEM);
    endfunction : op_is_mem

    assign is_mem_op   = op_is_mem(i_CMD.op);
    assign is_imm_op   = (i_CMD.op != nla_pkg::NLA_OP_NONE) && !is_mem_op;
    // Indexed forms take the pointer, direct forms the decoded address
    assign o_MEM_RADDR = i_CMD.indexed ? i_INDEX_PTR : i_CMD.addr;
    assign o_WREG_RSEL = i_CMD.wsel;
    // Memory ops pair memory with result_holder, immediate ops pair wreg with imm
    assign logic_a     = is_mem_op ? i_MEM_RDATA : i_WREG_RDATA;

    nla_logic_unit u_logic (
        .i_op      (i_CMD.op),
        .i_a       (logic_a),
        .i_b       (is_mem_op ? result_holder_q : i_CMD.imm),
        .o_y       (logic_y),
        .o_is_logic(logic_hit)
    );

    // ************************************************************
    // Arithmetic
    // ************************************************************
    assign sub_sel = (i_CMD.op == nla_pkg::NLA_OP_SBC_IMM) ||
                     (i_CMD.op == nla_pkg::NLA_OP_SUB_IMM);

    always_comb begin
        unique case (i_CMD.op)
            nla_pkg::NLA_OP_ADC_IMM, nla_pkg::NLA_OP_SBC_IMM: cin = carry_bit_q;
            nla_pkg::NLA_OP_SUB_IMM:                          cin = 1'b1;
            default:                                          cin = 1'b0;
        endcase
    end

    nla_adder u_adder (
        .i_a     (i_WREG_RDATA),
        .i_b     (i_CMD.imm),
        .i_invert(sub_sel),
        .i_cin   (cin),
        .o_sum   (sum),
        .o_cout  (cout)
    );

    always_comb begin
        result_d = result_holder_q;
        carry_d  = carry_bit_q;
        if (logic_hit) begin
            result_d = logic_y;
        end else if (is_imm_op) begin
            result_d = sum;
            // Keep-carry add is the only arithmetic form that spares the flag
            if (i_CMD.op != nla_pkg::NLA_OP_ADN_IMM) begin
                carry_d = cout;
            end
        end
    end

    // ************************************************************
    // State
    // ************************************************************
    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            result_holder_q <= `NLA_RESULT_RST;
        end else begin
            result_holder_q <= result_d;
        end
    end

    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            carry_bit_q <= `NLA_CARRY_RST;
        end else begin
            carry_bit_q <= carry_d;
        end
    end

    // ************************************************************
    // Write-back, registered one cycle after the operation
    // ************************************************************
    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            o_MEM_WR <= '0;
        end else begin
            o_MEM_WR.we   <= is_mem_op && i_CMD.star;
            o_MEM_WR.addr <= o_MEM_RADDR;
            o_MEM_WR.data <= result_d;
        end
    end

    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            o_WREG_WE    <= 1'b0;
            o_WREG_WSEL  <= 4'h0;
            o_WREG_WDATA <= 4'h0;
        end else begin
            o_WREG_WE    <= is_imm_op && i_CMD.star;
            o_WREG_WSEL  <= i_CMD.wsel;
            o_WREG_WDATA <= result_d;
        end
    end

    assign o_RESULT = result_holder_q;
    assign o_CARRY  = carry_bit_q;
endmodule : nla_alu

/* File: verif/nla_alu_asserts.sv */
// Port-level checks for the nibble datapath
`timescale 1ns/1ns
module nla_alu_asserts (
    input wire logic             I_CLK,
    input wire logic             I_RESET,
    input wire nla_pkg::nla_cmd_s i_CMD,
    input wire logic [6:0]       i_INDEX_PTR,
    input wire logic [3:0]       i_MEM_RDATA,
    input wire logic [3:0]       i_WREG_RDATA,
    input wire logic [6:0]       o_MEM_RADDR,
    input wire logic [3:0]       o_WREG_RSEL,
    input wire nla_pkg::nla_wr_s o_MEM_WR,
    input wire logic             o_WREG_WE,
    input wire logic [3:0]       o_WREG_WSEL,
    input wire logic [3:0]       o_WREG_WDATA,
    input wire logic [3:0]       o_RESULT,
    input wire logic             o_CARRY
);
    default clocking @(posedge I_CLK); endclocking
    default disable iff (I_RESET);
    logic [4:0] nxt;
    logic [4:0] w;
    logic [4:0] k;
    logic       imm;
    logic       mem;
    logic       ari;
    assign imm = i_CMD.op >= nla_pkg::NLA_OP_ADC_IMM;
    assign mem = i_CMD.op != nla_pkg::NLA_OP_NONE && !imm;
    assign ari = imm && i_CMD.op <= nla_pkg::NLA_OP_SUB_IMM;
    // Expected carry and result after the op now on the command port
    always_comb begin
        w = {1'b0, i_WREG_RDATA};
        k = {1'b0, i_CMD.imm};
        nxt = {o_CARRY, o_RESULT};
        case (i_CMD.op)
            nla_pkg::NLA_OP_XOR_MEM: nxt[3:0] = i_MEM_RDATA ^ o_RESULT;
            nla_pkg::NLA_OP_OR_MEM:  nxt[3:0] = i_MEM_RDATA | o_RESULT;
            nla_pkg::NLA_OP_AND_MEM: nxt[3:0] = i_MEM_RDATA & o_RESULT;
            nla_pkg::NLA_OP_ADC_IMM: nxt = w + k + {4'h0, o_CARRY};
            nla_pkg::NLA_OP_SBC_IMM: nxt = w + (k ^ 5'h0F) + {4'h0, o_CARRY};
            nla_pkg::NLA_OP_ADD_IMM: nxt = w + k;
            nla_pkg::NLA_OP_SUB_IMM: nxt = w + (k ^ 5'h0F) + 5'h01;
            nla_pkg::NLA_OP_ADN_IMM: nxt[3:0] = w[3:0] + k[3:0];
            nla_pkg::NLA_OP_AND_IMM: nxt[3:0] = w[3:0] & k[3:0];
            nla_pkg::NLA_OP_XOR_IMM: nxt[3:0] = w[3:0] ^ k[3:0];
            default: ;
        endcase
    end
    chk_mem_addr: assert property (mem |-> o_MEM_RADDR ==
        (i_CMD.indexed ? i_INDEX_PTR : i_CMD.addr)) else $error("memory address wrong");
    chk_arith_sum: assert property (ari |=> {o_CARRY, o_RESULT} == $past(nxt))
        else $error("sum or carry wrong");
    chk_logic_value: assert property (mem || (imm && !ari) |=>
        {o_CARRY, o_RESULT} == $past(nxt)) else $error("logic result wrong");
    chk_carry_kept: assert property (i_CMD.op == nla_pkg::NLA_OP_ADN_IMM |=>
        $stable(o_CARRY)) else $error("carry moved");
    chk_mem_store: assert property (mem && i_CMD.star |=> o_MEM_WR.we &&
        o_MEM_WR.addr == $past(o_MEM_RADDR) && o_MEM_WR.data == o_RESULT)
        else $error("memory store wrong");
    chk_mem_quiet: assert property (!(mem && i_CMD.star) |=> !o_MEM_WR.we)
        else $error("stray memory store");
    chk_wreg_store: assert property (imm && i_CMD.star |=> o_WREG_WE &&
        o_WREG_WSEL == $past(i_CMD.wsel) && o_WREG_WDATA == o_RESULT)
        else $error("register store wrong");
    chk_wreg_quiet: assert property (!(imm && i_CMD.star) |=> !o_WREG_WE)
        else $error("stray register store");
    cover property (ari && i_CMD.star);
    cover property (mem && i_CMD.indexed && i_CMD.star);
    cover property (i_CMD.op == nla_pkg::NLA_OP_ADN_IMM);
endmodule : nla_alu_asserts

/* File: verif/nla_partner.sv */
// Data memory and working registers on the far side of the datapath
`timescale 1ns/1ns
module nla_partner (
    input  wire logic             i_clk,
    input  wire logic [6:0]       i_raddr,
    input  wire logic [3:0]       i_rsel,
    input  wire nla_pkg::nla_wr_s i_wr,
    input  wire logic             i_wwe,
    input  wire logic [3:0]       i_wsel,
    input  wire logic [3:0]       i_wdata,
    output logic [3:0]            o_mem,
    output logic [3:0]            o_wreg
);
    // Each cell starts at its low address bits so expected values stay easy
    logic [3:0] mem_q [128];
    logic [3:0] wreg_q [16];
    initial begin
        foreach (mem_q[a]) mem_q[a] = 4'(a);
        foreach (wreg_q[r]) wreg_q[r] = 4'(r);
    end
    always @(posedge i_clk) begin
        if (i_wr.we) mem_q[i_wr.addr] <= i_wr.data;
        if (i_wwe) wreg_q[i_wsel] <= i_wdata;
    end
    assign o_mem = mem_q[i_raddr];
    assign o_wreg = wreg_q[i_rsel];
endmodule : nla_partner

/* File: verif/nla_alu_bench.sv */
// Self-checking bench for the nibble datapath
`timescale 1ns/1ns
module nla_alu_bench;
    logic              I_CLK = 1'b0;
    logic              I_RESET = 1'b1;
    nla_pkg::nla_cmd_s cmd = '0;
    nla_pkg::nla_wr_s  mwr;
    logic [6:0]        raddr;
    logic [3:0]        rsel, mrd, wrd, wsel, wdata, result;
    logic              wwe, carry;
    logic [6:0]        idx = 7'h29;
    int                mismatches = 0;
    int                tests_run = 0;
    // Row: op, star/indexed, addr, wsel, imm, then expected {carry, result}
    logic [31:0] rows [28] = '{32'h62009F18, 32'h82002F11, 32'h40009710, 32'h50002011,
        32'h52006313, 32'h7000450F, 32'h9200F606, 32'h40006F12, 32'hA000F315, 32'h70000010,
        32'hA2001A1B, 32'h10130018, 32'h6000100B, 32'h9000FC04, 32'h2300000D, 32'h80002E0F,
        32'h3100000D, 32'h80002506, 32'h1300000B, 32'h32150001, 32'h207E000F, 32'h60003D10,
        32'h10150011, 32'h2100001B, 32'h4200540A, 32'h7200780F, 32'h60005610, 32'h70007F10};
    always #50 I_CLK = ~I_CLK;
    nla_alu DUT (.I_CLK, .I_RESET, .i_CMD(cmd), .i_INDEX_PTR(idx), .i_MEM_RDATA(mrd),
        .i_WREG_RDATA(wrd), .o_MEM_RADDR(raddr), .o_WREG_RSEL(rsel), .o_MEM_WR(mwr),
        .o_WREG_WE(wwe), .o_WREG_WSEL(wsel), .o_WREG_WDATA(wdata), .o_RESULT(result),
        .o_CARRY(carry));
    nla_partner u_far (.i_clk(I_CLK), .i_raddr(raddr), .i_rsel(rsel), .i_wr(mwr),
        .i_wwe(wwe), .i_wsel(wsel), .i_wdata(wdata), .o_mem(mrd), .o_wreg(wrd));
    function automatic nla_pkg::nla_cmd_s row_cmd(input logic [31:0] r);
        return '{nla_pkg::nla_op_e'(r[31:28]), r[25], r[24], r[22:16], r[15:12], r[11:8]};
    endfunction : row_cmd
    task check(input logic [4:0] got, input logic [4:0] want);
        tests_run++;
        if (got !== want) begin
            $display("wrong value at %0t: got %h, expected %h", $time, got, want);
            mismatches++;
        end
    endtask : check
    task end_of_test;
        $display("comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : end_of_test
    // Whole run is under 50 cycles, so 400 means a hang
    initial begin
        #(100 * 400);
        mismatches++;
        end_of_test();
    end
    initial begin
        repeat (8) @(posedge I_CLK);
        I_RESET <= 1'b0;
        for (int i = 0; i <= 28; i++) begin
            @(posedge I_CLK);
            cmd <= (i < 28) ? row_cmd(rows[i]) : '0;
            #1;
            if (i > 0) check({carry, result}, rows[i - 1][4:0]);
        end
        $display("table test done");
        repeat (2) @(posedge I_CLK);
        #1 check({carry, result}, 5'h10);
        $display("idle hold test done");
        @(posedge I_CLK) I_RESET <= 1'b1;
        @(posedge I_CLK) #1 check({carry, result}, 5'h00);
        @(posedge I_CLK);
        I_RESET <= 1'b0;
        cmd <= row_cmd(32'h60003D10);
        @(posedge I_CLK) cmd <= '0;
        #1 check({carry, result}, 5'h10);
        $display("reset test done");
        // Move the pointer so the indexed read cannot lean on a fixed address
        @(posedge I_CLK) begin
            idx <= 7'h15;
            cmd <= row_cmd(32'h21000011);
        end
        @(posedge I_CLK) cmd <= '0;
        #1 check({carry, result}, 5'h11);
        $display("pointer move test done");
        end_of_test();
    end
endmodule : nla_alu_bench
bind nla_alu nla_alu_asserts u_chk (.I_CLK, .I_RESET, .i_CMD, .i_INDEX_PTR, .i_MEM_RDATA,
    .i_WREG_RDATA, .o_MEM_RADDR, .o_WREG_RSEL, .o_MEM_WR, .o_WREG_WE, .o_WREG_WSEL,
    .o_WREG_WDATA, .o_RESULT, .o_CARRY);
